// ---- hdl/ldl_pkg.sv ----
package ldl_pkg;
   localparam int CLK_MHZ = 20;
   localparam int SECOND_MS = 1000;
   localparam int SECOND_CYCLES = SECOND_MS * 1000 * CLK_MHZ;
   localparam int EXZ_W = 16;
   localparam int RUN_W = 7;
   localparam int LOS_W = 12;
   localparam int WIN_W = 8;
   localparam int SUB_LEN = 8;
   localparam logic [1:0] ZERO_COUNT_ON = 2'h1;
   localparam logic [RUN_W-1:0] EXZ_AMI_ANSI = 7'h0F;
   localparam logic [RUN_W-1:0] EXZ_AMI_FCC = 7'h50;
   localparam logic [RUN_W-1:0] EXZ_B8ZS = 7'h07;
   localparam logic [RUN_W-1:0] EXZ_HDB3 = 7'h03;
   localparam logic [LOS_W-1:0] LOS_T1_I431 = 12'h608;
   localparam logic [LOS_W-1:0] LOS_E1_G775 = 12'h020;
   localparam logic [LOS_W-1:0] LOS_E1_I431 = 12'h800;
   localparam logic [WIN_W-1:0] WIN_T1_LEN = 8'h80;
   localparam logic [WIN_W-1:0] WIN_T1_MARKS = 8'h10;
   localparam logic [RUN_W-1:0] WIN_T1_ZEROS = 7'h64;
   localparam logic [WIN_W-1:0] WIN_E1_LEN = 8'h20;
   localparam logic [WIN_W-1:0] WIN_E1_MARKS = 8'h04;
   localparam logic [RUN_W-1:0] WIN_E1_ZEROS = 7'h10;
   typedef logic [1:0] ldl_sym_type;
   typedef enum logic {LINK_OK, LINK_LOST} ldl_los_type;
endpackage : ldl_pkg

// ---- hdl/ldl_stream_if.sv ----
`timescale 1ns/10ps
interface ldl_stream_if #(parameter int WIDTH = 1) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ldl_stream_if

// ---- hdl/ldl_fifo.sv ----
`timescale 1ns/10ps
module ldl_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic  clk,     // system clock
   input wire logic  rst,     // sync reset
   ldl_stream_if.snk fillPort,  // write side
   ldl_stream_if.src drainPort  // read side
);
   import ldl_pkg::*;
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_reg;
   logic [AW:0]      rdPtr_reg;
   logic             full;
   logic             empty;
   logic             doWrite;
   logic             doRead;

   assign empty = (wrPtr_reg == rdPtr_reg);
   assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
   assign fillPort.ready = !full;
   assign drainPort.valid = !empty;
   assign drainPort.data = mem[rdPtr_reg[AW-1:0]];
   assign doWrite = fillPort.valid && !full;
   assign doRead = drainPort.ready && !empty;

   always_ff @(posedge clk)
   begin
      if (doWrite)
         mem[wrPtr_reg[AW-1:0]] <= fillPort.data;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         wrPtr_reg <= '0;
      else if (doWrite)
         wrPtr_reg <= wrPtr_reg + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rdPtr_reg <= '0;
      else if (doRead)
         rdPtr_reg <= rdPtr_reg + 1'b1;
   end
endmodule : ldl_fifo

// ---- hdl/ldl_line_decoder.sv ----
`timescale 1ns/10ps
module ldl_line_decoder #(
   parameter int FIFO_DEPTH = 16,
   parameter int SECOND_COUNT = ldl_pkg::SECOND_CYCLES,
   parameter logic [ldl_pkg::LOS_W-1:0] T1_ANSI_LOS_BITS = ldl_pkg::LOS_T1_I431
) (
   input  wire logic                      sys_clk,                 // 20 MHz
   input  wire logic                      rst,                     // sync, high
   input  wire logic                      rxPos,                   // positive rail pin
   input  wire logic                      rxNeg,                   // negative rail pin
   input  wire logic                      rxClk,                   // recovered clock pin
   input  wire logic                      ampLow,                  // amplitude below Q
   input  wire logic                      ampHigh,                 // amplitude above Q+4 dB
   input  wire logic                      e1Mode,                  // 1 = E1, 0 = T1/J1
   input  wire logic                      lineCodeSelect,          // 1 = B8ZS/HDB3
   input  wire logic                      zeroRuleSelect,          // 1 = FCC
   input  wire logic [1:0]                zeroCountEnable,         // 01 counts
   input  wire logic                      counterReportMode,       // 1 = auto
   input  wire logic                      counterTransferRequest,  // rise copies
   input  wire logic                      counterOverflowIntEn,    // enable
   input  wire logic                      violationIntEn,          // enable
   input  wire logic                      zeroIntEn,               // enable
   input  wire logic                      signalLossEdgeSelect,    // 1 = both edges
   input  wire logic                      signalLossIntEn,         // enable
   input  wire logic                      lossCriteriaSelect,      // 1 = I.431
   input  wire logic [4:0]                lossThreshold,           // Q setting
   input  wire logic                      allOnesInsert,           // ones during loss
   input  wire logic                      violationFlagClr,        // clear pulse
   input  wire logic                      zeroFlagClr,             // clear pulse
   input  wire logic                      counterOverflowFlagClr,  // clear pulse
   input  wire logic                      signalLossFlagClr,       // clear pulse
   input  wire logic                      outReady,                // drain ready
   output logic                           outData,                 // decoded bit
   output logic                           outValid,                // bit available
   output logic                           decodeReady,             // fifo has room
   output logic                           bpvEvent,                // to perf monitor
   output logic                           cvEvent,                 // code violation
   output logic                           exzEvent,                // excessive zeros
   output logic [ldl_pkg::EXZ_W-1:0]      holdCount,               // held count
   output logic                           violationFlag,           // sticky
   output logic                           zeroFlag,                // sticky
   output logic                           counterOverflowFlag,     // sticky
   output logic                           signalLossFlag,          // sticky
   output logic                           signalLossState,         // current loss
   output logic [4:0]                     lossThresholdOut,        // to comparator
   output logic                           intOut                   // interrupt
);
   import ldl_pkg::*;
   localparam int SEC_W = $clog2(SECOND_COUNT);
   localparam logic [RUN_W-1:0] RUN_MAX = '1;

   logic [4:0]          syncA_reg;
   logic [4:0]          syncB_reg;
   logic                clkPrev_reg;
   ldl_sym_type         symWin_reg [SUB_LEN];
   logic [SUB_LEN-1:0]  subMask_reg;
   ldl_sym_type         lastPulse_reg;
   ldl_sym_type         lastV_reg;
   logic [RUN_W-1:0]    runLen_reg;
   logic [RUN_W-1:0]    runLen_next;
   logic                outBit_reg;
   logic                outStrobe_reg;
   logic [EXZ_W-1:0]    cnt_reg;
   logic                trfPrev_reg;
   logic [SEC_W-1:0]    secCnt_reg;
   ldl_los_type         los_reg;
   logic                losPrev_reg;
   logic [LOS_W-1:0]    lowRun_reg;
   logic [WIN_W-1:0]    winCnt_reg;
   logic [WIN_W-1:0]    marks_reg;
   logic                winOk_reg;
   logic                strobe;
   logic                ampLowS;
   logic                ampHighS;
   ldl_sym_type         newSym;
   ldl_sym_type         w [SUB_LEN];
   ldl_sym_type         hdbRef;
   logic                b8zsHit;
   logic                hdb3Hit;
   logic                subHit;
   logic                masked;
   logic                violation;
   logic                bpvEv;
   logic                cvEv;
   logic                violEv;
   logic                exzEv;
   logic                countEv;
   logic                secTick;
   logic                trfTick;
   logic                overflowEv;
   logic                pulse;
   logic [RUN_W-1:0]    exzLimit;
   logic                winEnd;
   logic                winPass;
   logic [WIN_W-1:0]    marksNew;
   logic                winOkNew;

   function automatic logic isPulse(input ldl_sym_type s);
      return |s;
   endfunction : isPulse

   function automatic logic sameSign(input ldl_sym_type a, input ldl_sym_type b);
      return (a == b) && (|a);
   endfunction : sameSign

   // rails, clock and amplitude come from outside
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         syncA_reg <= '0;
         syncB_reg <= '0;
         clkPrev_reg <= 1'b0;
      end
      else
      begin
         syncA_reg <= {ampHigh, ampLow, rxClk, rxNeg, rxPos};
         syncB_reg <= syncA_reg;
         clkPrev_reg <= syncB_reg[2];
      end
   end

   assign strobe = syncB_reg[2] && !clkPrev_reg;
   assign newSym = {syncB_reg[0], syncB_reg[1] && !syncB_reg[0]};
   assign ampLowS = syncB_reg[3];
   assign ampHighS = syncB_reg[4];

   always_comb
   begin
      for (int i = 0; i < SUB_LEN; i++)
         w[i] = symWin_reg[i];
   end

   assign pulse = isPulse(w[0]);
   assign b8zsHit = (w[0] == 2'h0) && (w[1] == 2'h0) && (w[2] == 2'h0)
                    && sameSign(w[3], lastPulse_reg) && isPulse(w[4])
                    && !sameSign(w[4], w[3]) && (w[5] == 2'h0)
                    && sameSign(w[6], w[4]) && sameSign(w[7], w[3]);
   assign hdbRef = pulse ? w[0] : lastPulse_reg;
   assign hdb3Hit = (w[1] == 2'h0) && (w[2] == 2'h0) && sameSign(w[3], hdbRef)
                    && (!pulse || !sameSign(w[0], lastPulse_reg));
   assign subHit = strobe && lineCodeSelect && !subMask_reg[0]
                   && (e1Mode ? hdb3Hit : b8zsHit);
   assign masked = subMask_reg[0] || subHit;
   assign violation = sameSign(w[0], lastPulse_reg);
   assign bpvEv = strobe && !lineCodeSelect && violation;
   assign cvEv = strobe && lineCodeSelect
                 && ((violation && !masked) || (subHit && e1Mode && sameSign(w[3], lastV_reg)));
   assign violEv = bpvEv || cvEv;

   always_comb
   begin
      if (!lineCodeSelect)
         exzLimit = zeroRuleSelect ? EXZ_AMI_FCC : EXZ_AMI_ANSI;
      else
         exzLimit = e1Mode ? EXZ_HDB3 : EXZ_B8ZS;
   end

   assign runLen_next = pulse ? '0 : ((runLen_reg == RUN_MAX) ? runLen_reg : runLen_reg + 1'b1);
   assign exzEv = strobe && !pulse && (runLen_reg == exzLimit);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < SUB_LEN; i++)
            symWin_reg[i] <= '0;
         subMask_reg <= '0;
         lastPulse_reg <= '0;
         lastV_reg <= '0;
         runLen_reg <= '0;
      end
      else if (strobe)
      begin
         for (int i = 0; i < SUB_LEN - 1; i++)
            symWin_reg[i] <= symWin_reg[i+1];
         symWin_reg[SUB_LEN-1] <= newSym;
         subMask_reg <= {1'b0, subMask_reg[SUB_LEN-1:1]};
         if (subHit)
            subMask_reg <= e1Mode ? SUB_LEN'(8'h07) : SUB_LEN'(8'h7F);
         if (subHit)
            lastV_reg <= w[3];
         if (pulse)
            lastPulse_reg <= w[0];
         runLen_reg <= runLen_next;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         outBit_reg <= 1'b0;
         outStrobe_reg <= 1'b0;
         bpvEvent <= 1'b0;
         cvEvent <= 1'b0;
         exzEvent <= 1'b0;
      end
      else
      begin
         outStrobe_reg <= strobe;
         if (strobe)
            outBit_reg <= ((los_reg == LINK_LOST) && allOnesInsert) || (pulse && !masked);
         bpvEvent <= bpvEv;
         cvEvent <= cvEv;
         exzEvent <= exzEv;
      end
   end

   assign secTick = (secCnt_reg == SEC_W'(SECOND_COUNT - 1));
   always_ff @(posedge sys_clk)
   begin
      if (rst || secTick)
         secCnt_reg <= '0;
      else
         secCnt_reg <= secCnt_reg + 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         trfPrev_reg <= 1'b0;
      else
         trfPrev_reg <= counterTransferRequest;
   end

   assign trfTick = counterReportMode ? secTick : (counterTransferRequest && !trfPrev_reg);
   assign countEv = exzEv && (zeroCountEnable == ZERO_COUNT_ON);
   assign overflowEv = countEv && !trfTick && (&cnt_reg);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cnt_reg <= '0;
      else if (trfTick)
         cnt_reg <= countEv ? EXZ_W'(1) : '0;
      else if (countEv)
         cnt_reg <= cnt_reg + 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         holdCount <= '0;
      else if (trfTick)
         holdCount <= cnt_reg;
   end

   function automatic logic [LOS_W-1:0] losLimit(input logic e1, input logic loss_criteria_select);
      if (e1)
         return loss_criteria_select ? LOS_E1_I431 : LOS_E1_G775;
      return loss_criteria_select ? LOS_T1_I431 : T1_ANSI_LOS_BITS;
   endfunction : losLimit

   assign marksNew = marks_reg + WIN_W'(pulse);
   assign winOkNew = winOk_reg && ampHighS
                     && (runLen_next < (e1Mode ? WIN_E1_ZEROS : WIN_T1_ZEROS));
   assign winEnd = (winCnt_reg == ((e1Mode ? WIN_E1_LEN : WIN_T1_LEN) - 1'b1));
   assign winPass = winOkNew && (marksNew >= (e1Mode ? WIN_E1_MARKS : WIN_T1_MARKS));

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         lowRun_reg <= '0;
      else if (strobe)
         lowRun_reg <= (ampLowS && !(&lowRun_reg)) ? lowRun_reg + 1'b1 : (ampLowS ? lowRun_reg : '0);
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         los_reg <= LINK_OK;
         winCnt_reg <= '0;
         marks_reg <= '0;
         winOk_reg <= 1'b1;
      end
      else
      begin
         case (los_reg)
            LINK_OK:
            begin
               winCnt_reg <= '0;
               marks_reg <= '0;
               winOk_reg <= 1'b1;
               if (strobe && ampLowS && (lowRun_reg == losLimit(e1Mode, lossCriteriaSelect) - 1'b1))
                  los_reg <= LINK_LOST;
            end
            LINK_LOST:
            begin
               if (strobe)
               begin
                  winCnt_reg <= winEnd ? '0 : winCnt_reg + 1'b1;
                  marks_reg <= winEnd ? '0 : marksNew;
                  winOk_reg <= winEnd ? 1'b1 : winOkNew;
                  if (winEnd && winPass)
                     los_reg <= LINK_OK;
               end
            end
            default:
               los_reg <= LINK_OK;
         endcase
      end
   end

   assign signalLossState = (los_reg == LINK_LOST);

   // flags: set wins over clear
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         violationFlag <= 1'b0;
         zeroFlag <= 1'b0;
         counterOverflowFlag <= 1'b0;
         signalLossFlag <= 1'b0;
         losPrev_reg <= 1'b0;
         intOut <= 1'b0;
         lossThresholdOut <= '0;
      end
      else
      begin
         losPrev_reg <= signalLossState;
         lossThresholdOut <= lossThreshold;
         violationFlag <= violEv || (violationFlag && !violationFlagClr);
         zeroFlag <= exzEv || (zeroFlag && !zeroFlagClr);
         counterOverflowFlag <= overflowEv || (counterOverflowFlag && !counterOverflowFlagClr);
         signalLossFlag <= (signalLossState && !losPrev_reg)
                           || (signalLossEdgeSelect && !signalLossState && losPrev_reg)
                           || (signalLossFlag && !signalLossFlagClr);
         intOut <= (violationFlag && violationIntEn) || (zeroFlag && zeroIntEn)
                   || (counterOverflowFlag && counterOverflowIntEn)
                   || (signalLossFlag && signalLossIntEn);
      end
   end

   ldl_stream_if #(.WIDTH(1)) fillSide ();
   ldl_stream_if #(.WIDTH(1)) drainSide ();

   assign fillSide.valid = outStrobe_reg;
   assign fillSide.data = outBit_reg;
   assign decodeReady = fillSide.ready;
   assign outValid = drainSide.valid;
   assign outData = drainSide.data;
   assign drainSide.ready = outReady;

   ldl_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) bitFifo (
      .clk       (sys_clk),
      .rst       (rst),
      .fillPort  (fillSide),
      .drainPort (drainSide)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_bpv_ami_only: assert property (bpvEvent |-> !$past(lineCodeSelect))
      else $error("bipolar violation reported under coded mode");
   a_cv_coded_only: assert property (cvEvent |-> $past(lineCodeSelect))
      else $error("code violation reported under AMI");
   a_exz_limit: assert property (exzEvent |-> $past(runLen_reg) == $past(exzLimit))
      else $error("excessive zero raised at wrong run length");
   a_cnt_gated: assert property ((zeroCountEnable != ZERO_COUNT_ON) && !trfTick
      |=> cnt_reg == $past(cnt_reg))
      else $error("counter moved while disabled");
   a_hold_copy: assert property (trfTick |=> holdCount == $past(cnt_reg))
      else $error("holding value differs from counter");
   a_cnt_restart: assert property (trfTick && !countEv |=> cnt_reg == '0)
      else $error("counter not cleared after transfer");
   a_ovf_flag: assert property (overflowEv |=> counterOverflowFlag && cnt_reg == '0)
      else $error("overflow not flagged");
   a_viol_flag: assert property (violEv |=> violationFlag ##1 intOut || !violationIntEn)
      else $error("violation flag or interrupt missing");
   a_loss_cause: assert property ($rose(signalLossState) |-> $past(ampLowS))
      else $error("loss declared without low amplitude");
   a_loss_flag: assert property ($rose(signalLossState) |=> signalLossFlag)
      else $error("loss edge did not set flag");
   a_loss_int: assert property (signalLossFlag && signalLossIntEn |=> intOut)
      else $error("loss interrupt missing");
   a_ones_fill: assert property (outStrobe_reg && $past(signalLossState && allOnesInsert)
      |-> outBit_reg)
      else $error("ones not inserted during loss");

   c_subst: cover property (subHit);
   c_transfer: cover property (trfTick && cnt_reg != '0);
   c_loss_clear: cover property ($fell(signalLossState));
   c_fifo_full: cover property (!decodeReady);
endmodule : ldl_line_decoder

// ---- test/ldl_line_model.sv ----
`timescale 1ns/10ps
module ldl_line_model (
   input  wire logic clk,   // system clock
   output logic      rxPos, // positive rail
   output logic      rxNeg, // negative rail
   output logic      rxClk  // recovered bit clock
);
   initial
   begin
      rxPos = 1'b0;
      rxNeg = 1'b0;
      rxClk = 1'b0;
   end
   // one bit period: clock high then low, 4 cycles each, rails held all period
   task sendSym(input logic [1:0] s);
      rxPos = s[1];
      rxNeg = s[0];
      rxClk = 1'b1;
      repeat (4) @(posedge clk);
      #1 rxClk = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask : sendSym
endmodule : ldl_line_model

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import ldl_pkg::*;
   localparam int SEC = 2000;
   localparam logic [1:0] PS = 2'h2, NS = 2'h1, ZS = 2'h0;
   localparam int LIM [8] = '{15, 16, 80, 81, 7, 8, 3, 4};
   logic sysClk = 1'b0, rst = 1'b1, rxPos, rxNeg, rxClk, outData, outValid, decodeReady;
   logic ampLow = 1'b0, ampHigh = 1'b1, e1Mode = 1'b0, lineCodeSelect = 1'b0;
   logic zeroRuleSelect = 1'b0, counterReportMode = 1'b0, counterTransferRequest = 1'b0;
   logic counterOverflowIntEn = 1'b1, violationIntEn = 1'b0, zeroIntEn = 1'b0;
   logic signalLossEdgeSelect = 1'b1, signalLossIntEn = 1'b0, lossCriteriaSelect = 1'b0;
   logic allOnesInsert = 1'b1, violationFlagClr = 1'b0, zeroFlagClr = 1'b0;
   logic counterOverflowFlagClr = 1'b0, signalLossFlagClr = 1'b0, outReady = 1'b1;
   logic bpvEvent, cvEvent, exzEvent, violationFlag, zeroFlag, counterOverflowFlag;
   logic signalLossFlag, signalLossState, intOut, lastBit, lastPos = 1'b0;
   logic [1:0] zeroCountEnable = 2'h1;
   logic [4:0] lossThreshold = 5'h0B, lossThresholdOut;
   logic [EXZ_W-1:0] holdCount;
   int fails = 0, checkCount = 0, cycles = 0, bpvN = 0, cvN = 0, exzN = 0, base;
   int oneN = 0, ones0;

   ldl_line_decoder #(.SECOND_COUNT(SEC), .T1_ANSI_LOS_BITS(12'h014)) dut (
      .sys_clk(sysClk), .rst, .rxPos, .rxNeg, .rxClk, .ampLow, .ampHigh, .e1Mode,
      .lineCodeSelect, .zeroRuleSelect, .zeroCountEnable, .counterReportMode,
      .counterTransferRequest, .counterOverflowIntEn, .violationIntEn, .zeroIntEn,
      .signalLossEdgeSelect, .signalLossIntEn, .lossCriteriaSelect, .lossThreshold,
      .allOnesInsert, .violationFlagClr, .zeroFlagClr, .counterOverflowFlagClr,
      .signalLossFlagClr, .outReady, .outData, .outValid, .decodeReady, .bpvEvent,
      .cvEvent, .exzEvent, .holdCount, .violationFlag, .zeroFlag, .counterOverflowFlag,
      .signalLossFlag, .signalLossState, .lossThresholdOut, .intOut);
   ldl_line_model line (.clk(sysClk), .rxPos, .rxNeg, .rxClk);

   always #25 sysClk = ~sysClk;
   // event tally, last drained bit, hang guard
   always @(posedge sysClk)
   begin
      cycles++;
      if (bpvEvent === 1'b1) bpvN++;
      if (cvEvent === 1'b1) cvN++;
      if (exzEvent === 1'b1) exzN++;
      if (outValid === 1'b1 && outData === 1'b1) oneN++;
      if (outValid === 1'b1) lastBit <= outData;
      if (cycles == 40000)
      begin
         fails++;
         final_report();
      end
   end

   task check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checkCount++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check
   task checkBit(input logic got, input logic exp, input string msg);
      checkCount++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask : checkBit
   task tick(input int n);
      repeat (n) @(posedge sysClk);
      #1;
   endtask : tick
   task tx(input logic [1:0] s);
      line.sendSym(s);
      if (s != ZS) lastPos = s[1];
   endtask : tx
   task zeros(input int n);
      repeat (n) tx(ZS);
   endtask : zeros
   task marks(input int n);
      repeat (n) tx(lastPos ? NS : PS);
   endtask : marks
   task zrun(input int n, input int exp);
      base = exzN;
      marks(1);
      zeros(n);
      marks(10);
      check(16'(exzN - base), 16'(exp), "zero run events");
   endtask : zrun
   task xfer();
      counterTransferRequest = 1'b1;
      tick(1);
      counterTransferRequest = 1'b0;
      tick(2);
   endtask : xfer

   task testBpv();
      violationIntEn = 1'b1;
      base = bpvN;
      marks(1);
      tx(lastPos ? PS : NS);
      marks(10);
      check(16'(bpvN - base), 16'h0001, "bipolar events");
      checkBit(violationFlag, 1'b1, "violation flag");
      checkBit(intOut, 1'b1, "violation int");
      violationFlagClr = 1'b1;
      violationIntEn = 1'b0;
      tick(1);
      violationFlagClr = 1'b0;
      tick(2);
      checkBit(intOut, 1'b0, "int masked");
   endtask : testBpv
   task testExz();
      for (int i = 0; i < 8; i++)
      begin
         zeroRuleSelect = (i > 1);
         lineCodeSelect = (i > 3);
         e1Mode = (i > 5);
         zrun(LIM[i], i % 2);
      end
      zeroIntEn = 1'b1;
      tick(3);
      checkBit(intOut, 1'b1, "zero int");
      zeroFlagClr = 1'b1;
      tick(1);
      zeroFlagClr = 1'b0;
      zeroIntEn = 1'b0;
      tick(2);
      checkBit(zeroFlag, 1'b0, "zero flag clear");
   endtask : testExz
   task testCount();
      e1Mode = 1'b0;
      lineCodeSelect = 1'b0;
      zeroRuleSelect = 1'b0;
      xfer();
      zrun(16, 1);
      zrun(16, 1);
      zeroCountEnable = 2'h2;
      zrun(16, 1);
      zeroCountEnable = 2'h1;
      xfer();
      check(holdCount, 16'h0002, "manual copy");
      xfer();
      check(holdCount, 16'h0000, "cleared count");
      checkBit(counterOverflowFlag, 1'b0, "no overflow");
   endtask : testCount
   task testHdb3();
      e1Mode = 1'b1;
      lineCodeSelect = 1'b1;
      base = cvN;
      marks(2);
      zeros(3);
      tx(lastPos ? PS : NS);
      tx(lastPos ? NS : PS);
      zeros(2);
      tx(lastPos ? PS : NS);
      marks(10);
      check(16'(cvN - base), 16'h0000, "valid substitutions");
      tx(lastPos ? PS : NS);
      marks(10);
      check(16'(cvN - base), 16'h0001, "bare violation");
   endtask : testHdb3
   task testB8zs();
      e1Mode = 1'b0;
      zeros(7);
      base = cvN;
      ones0 = oneN;
      marks(1);
      zeros(3);
      tx(lastPos ? PS : NS);
      tx(lastPos ? NS : PS);
      zeros(1);
      tx(lastPos ? PS : NS);
      tx(lastPos ? NS : PS);
      marks(10);
      check(16'(cvN - base), 16'h0000, "b8zs substitution");
      check(16'(oneN - ones0), 16'h0004, "substitution zeroed");
      tx(lastPos ? PS : NS);
      marks(10);
      check(16'(cvN - base), 16'h0001, "b8zs bare violation");
   endtask : testB8zs
   task testAuto();
      int i;
      e1Mode = 1'b0;
      lineCodeSelect = 1'b0;
      counterReportMode = 1'b1;
      tick(SEC + 100);
      zrun(16, 1);
      for (i = 0; i < SEC + 100 && holdCount !== 16'h0001; i++) tick(1);
      check(holdCount, 16'h0001, "auto copy");
      tick(SEC + 100);
      check(holdCount, 16'h0000, "auto empty");
      counterReportMode = 1'b0;
   endtask : testAuto
   task testLoss();
      signalLossIntEn = 1'b1;
      ampHigh = 1'b0;
      ampLow = 1'b1;
      zeros(17);
      checkBit(signalLossState, 1'b0, "no early loss");
      zeros(5);
      checkBit(signalLossState, 1'b1, "loss declared");
      checkBit(signalLossFlag, 1'b1, "loss flag");
      checkBit(intOut, 1'b1, "loss int");
      zeros(10);
      checkBit(lastBit, 1'b1, "all ones");
      signalLossFlagClr = 1'b1;
      tick(1);
      signalLossFlagClr = 1'b0;
      tick(1);
      checkBit(signalLossFlag, 1'b0, "loss flag clear");
      ampLow = 1'b0;
      ampHigh = 1'b1;
      marks(300);
      checkBit(signalLossState, 1'b0, "loss cleared");
      checkBit(signalLossFlag, 1'b1, "falling edge flag");
      signalLossEdgeSelect = 1'b0;
      e1Mode = 1'b1;
      signalLossFlagClr = 1'b1;
      ampHigh = 1'b0;
      ampLow = 1'b1;
      tick(1);
      signalLossFlagClr = 1'b0;
      zeros(31);
      checkBit(signalLossState, 1'b0, "e1 no early loss");
      zeros(2);
      checkBit(signalLossState, 1'b1, "e1 loss declared");
      signalLossFlagClr = 1'b1;
      ampLow = 1'b0;
      ampHigh = 1'b1;
      tick(1);
      signalLossFlagClr = 1'b0;
      marks(80);
      checkBit(signalLossState, 1'b0, "e1 loss cleared");
      checkBit(signalLossFlag, 1'b0, "rising edge only");
   endtask : testLoss

   task final_report();
      if (fails == 0 && checkCount > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   initial
   begin
      tick(8);
      rst = 1'b0;
      tick(2);
      check(16'(lossThresholdOut), 16'h000B, "threshold copy");
      testBpv();
      testExz();
      testCount();
      testHdb3();
      testB8zs();
      testAuto();
      testLoss();
      final_report();
   end
endmodule : testbench
